// ### logic/flash_multi_io_read.sv
// Read-command front end of a serial NOR flash: dual/quad output and I/O
// reads, command-skipping enhance mode, burst wrap configuration.
// Assumes link pins arrive asynchronously and are oversampled by clock;
// the array answers memData one clock after memAddr changes.
`timescale 1ns/1ns
`default_nettype none
`include "flash_multi_io_read_params.svh"

// Functional notes
// - sample on sclk rise, drive on fall
// - any start address, increment, roll over
// - 3Bh: x1 address, 8 dummy, x2 data
// - BBh: x2 address, 4 dummy, x2 data
// - quad reads need quad enable set
// - 6Bh: x1 address, 8 dummy, x4 data
// - EBh: x4 address, 2+4 dummy, x4 data
// - reads ignored while write in progress
// - only EBh enters enhance mode
// - toggling indicator keeps enhance, no opcode
// - non-toggling indicator leaves enhance next select
// - FFh during enhance exits to opcodes
// - C0h then enable nibble, depth nibble
// - depth codes 8/16/32/64, 1x disables
// - wrap inside aligned block within page
// - wrap off at reset, kept otherwise
// - EBh data output honours wrap
// - select high ends read, releases lines
// - dummy select lengthens I/O read dummies
module flash_multi_io_read #(
    parameter int ARRAY_ADDR_W = 21,
    parameter int AXI_ADDR_W = 4
) (
    input wire logic clock, // System clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic sclk, // Serial clock from host
    input wire logic csN, // Chip select, active low
    input wire logic [3:0] sioIn, // Data lines as seen at the pins
    output logic [3:0] sioOut, // Data lines driven value
    output logic [3:0] sioOe, // Data line output enables
    input wire logic writeInProgress, // Program/erase/status write busy
    output logic [ARRAY_ADDR_W-1:0] memAddr, // Array byte address
    input wire logic [7:0] memData, // Array byte at memAddr
    input wire logic [AXI_ADDR_W-1:0] awaddr, // AXI write address
    input wire logic awvalid, // AXI write address valid
    output logic awready, // AXI write address ready
    input wire logic [31:0] wdata, // AXI write data
    input wire logic [3:0] wstrb, // AXI write strobes
    input wire logic wvalid, // AXI write data valid
    output logic wready, // AXI write data ready
    output logic [1:0] bresp, // AXI write response
    output logic bvalid, // AXI write response valid
    input wire logic bready, // AXI write response ready
    input wire logic [AXI_ADDR_W-1:0] araddr, // AXI read address
    input wire logic arvalid, // AXI read address valid
    output logic arready, // AXI read address ready
    output logic [31:0] rdata, // AXI read data
    output logic [1:0] rresp, // AXI read response
    output logic rvalid, // AXI read data valid
    input wire logic rready // AXI read data ready
);
    flash_multi_io_read_pkg::linkIn_s syncA, syncB, syncC, pin, pinPrev;
    flash_multi_io_read_pkg::linkState_e state;
    flash_multi_io_read_pkg::readKind_e kind;
    flash_multi_io_read_pkg::wrapCfg_s wrapCfg;
    logic [1:0] ctrl;
    logic enhance, enhanceEntry, quadEnable, dummySelect, quadData;
    logic [7:0] opShift, dataShift, next_op, next_mode, dataSrc;
    logic [23:0] addrShift, next_addrShift;
    logic [3:0] modeBits, dummyLeft, dummyCount;
    logic [4:0] bitCnt, addrClocks;
    logic [2:0] byteLeft;
    logic sclkRise, sclkFall, csRise, csFall;
    logic [5:0] wrapMask;
    logic [ARRAY_ADDR_W-1:0] next_memAddr;
    logic [31:0] statusWord;
    assign quadEnable = ctrl[`CTRL_QUAD_ENABLE_BIT];
    assign dummySelect = ctrl[`CTRL_DUMMY_SELECT_BIT];

    // Three-stage sampling; a bit moves only when stages two and three agree
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            syncA <= '1;
            syncB <= '1;
            syncC <= '1;
            pin <= '1;
            pinPrev <= '1;
        end
        else
        begin
            syncA <= {sclk, csN, sioIn};
            syncB <= syncA;
            syncC <= syncB;
            pin <= (syncC & ~(syncB ^ syncC)) | (pin & (syncB ^ syncC));
            pinPrev <= pin;
        end
    end

    assign sclkRise = pin.sclk & ~pinPrev.sclk;
    assign sclkFall = ~pin.sclk & pinPrev.sclk;
    assign csRise = pin.csN & ~pinPrev.csN;
    assign csFall = ~pin.csN & pinPrev.csN;
    always_comb
    begin
        next_op = {opShift[6:0], pin.sio[0]};
        next_mode = {modeBits, pin.sio};
        case (kind)
            flash_multi_io_read_pkg::RD_DUAL_IO:
            begin
                next_addrShift = {addrShift[21:0], pin.sio[1:0]};
                addrClocks = `ADDR_CLOCKS_X2;
                dummyCount = dummySelect ? `DUMMY_DUAL_IO_LONG
                                         : `DUMMY_DUAL_IO_SHORT;
            end
            flash_multi_io_read_pkg::RD_QUAD_IO:
            begin
                next_addrShift = {addrShift[19:0], pin.sio};
                addrClocks = `ADDR_CLOCKS_X4;
                dummyCount = dummySelect ? `DUMMY_QUAD_IO_LONG
                                         : `DUMMY_QUAD_IO_SHORT;
            end
            default:
            begin
                next_addrShift = {addrShift[22:0], pin.sio[0]};
                addrClocks = `ADDR_CLOCKS_X1;
                dummyCount = `DUMMY_SINGLE_ADDR;
            end
        endcase
    end

    // Source of the next lanes: fresh array byte at a byte boundary
    assign quadData = kind[1];
    assign dataSrc = (byteLeft == 3'd0) ? memData : dataShift;
    assign wrapMask = 6'(({3'b000, 3'b111} << wrapCfg.depth)
                         | 6'((1 << wrapCfg.depth) - 1));

    always_comb
    begin
        if (wrapCfg.enable && kind == flash_multi_io_read_pkg::RD_QUAD_IO)
        begin
            next_memAddr = memAddr;
            next_memAddr[5:0] = (memAddr[5:0] & ~wrapMask)
                | ((memAddr[5:0] + 6'd1) & wrapMask);
        end
        else
        begin
            next_memAddr = memAddr + 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state <= flash_multi_io_read_pkg::ST_IDLE;
            kind <= flash_multi_io_read_pkg::RD_DUAL_OUT;
            wrapCfg <= '0;
            enhance <= 1'b0;
            enhanceEntry <= 1'b0;
            opShift <= 8'h00;
            addrShift <= 24'h000000;
            modeBits <= 4'h0;
            bitCnt <= 5'd0;
            dummyLeft <= 4'd0;
            dataShift <= 8'h00;
            byteLeft <= 3'd0;
            sioOut <= 4'h0;
            sioOe <= 4'h0;
            memAddr <= '0;
        end
        else if (csRise)
        begin
            state <= flash_multi_io_read_pkg::ST_IDLE;
            sioOe <= 4'h0;
        end
        else if (csFall)
        begin
            bitCnt <= 5'd0;
            byteLeft <= 3'd0;
            if (!enhance)
            begin
                state <= flash_multi_io_read_pkg::ST_OPCODE;
                enhanceEntry <= 1'b0;
            end
            else if (writeInProgress || !quadEnable)
            begin
                state <= flash_multi_io_read_pkg::ST_IGNORE;
            end
            else
            begin
                state <= flash_multi_io_read_pkg::ST_ADDR;
                kind <= flash_multi_io_read_pkg::RD_QUAD_IO;
                enhanceEntry <= 1'b1;
            end
        end
        else if (sclkRise)
        begin
            bitCnt <= bitCnt + 5'd1;
            case (state)
                flash_multi_io_read_pkg::ST_OPCODE:
                begin
                    opShift <= next_op;
                    if (bitCnt == 5'd7)
                    begin
                        bitCnt <= 5'd0;
                        state <= flash_multi_io_read_pkg::ST_IGNORE;
                        if (next_op == `OP_BURST_WRAP_CFG)
                        begin
                            state <= flash_multi_io_read_pkg::ST_WRAPCFG;
                        end
                        else if (writeInProgress)
                        begin
                            state <= flash_multi_io_read_pkg::ST_IGNORE;
                        end
                        else if (next_op == `OP_DUAL_OUTPUT_READ)
                        begin
                            state <= flash_multi_io_read_pkg::ST_ADDR;
                            kind <= flash_multi_io_read_pkg::RD_DUAL_OUT;
                        end
                        else if (next_op == `OP_DUAL_IO_READ)
                        begin
                            state <= flash_multi_io_read_pkg::ST_ADDR;
                            kind <= flash_multi_io_read_pkg::RD_DUAL_IO;
                        end
                        else if (next_op == `OP_QUAD_OUTPUT_READ && quadEnable)
                        begin
                            state <= flash_multi_io_read_pkg::ST_ADDR;
                            kind <= flash_multi_io_read_pkg::RD_QUAD_OUT;
                        end
                        else if (next_op == `OP_QUAD_IO_READ && quadEnable)
                        begin
                            state <= flash_multi_io_read_pkg::ST_ADDR;
                            kind <= flash_multi_io_read_pkg::RD_QUAD_IO;
                        end
                    end
                end
                flash_multi_io_read_pkg::ST_ADDR:
                begin
                    addrShift <= next_addrShift;
                    if (enhanceEntry && bitCnt == 5'd1
                        && next_addrShift[7:0] == `OP_ENHANCE_EXIT)
                    begin
                        enhance <= 1'b0;
                        state <= flash_multi_io_read_pkg::ST_IGNORE;
                    end
                    else if (bitCnt == addrClocks - 5'd1)
                    begin
                        bitCnt <= 5'd0;
                        memAddr <= next_addrShift[ARRAY_ADDR_W-1:0];
                        dummyLeft <= dummyCount;
                        if (kind == flash_multi_io_read_pkg::RD_QUAD_IO)
                        begin
                            state <= flash_multi_io_read_pkg::ST_MODE;
                        end
                        else
                        begin
                            state <= flash_multi_io_read_pkg::ST_DUMMY;
                        end
                    end
                end
                flash_multi_io_read_pkg::ST_MODE:
                begin
                    modeBits <= pin.sio;
                    if (bitCnt == `INDICATOR_CLOCKS - 5'd1)
                    begin
                        // Takes effect at the next select-low
                        enhance <= (next_mode[7:4] == ~next_mode[3:0]);
                        state <= flash_multi_io_read_pkg::ST_DUMMY;
                    end
                end
                flash_multi_io_read_pkg::ST_DUMMY:
                begin
                    dummyLeft <= dummyLeft - 4'd1;
                    if (dummyLeft == 4'd1)
                    begin
                        state <= flash_multi_io_read_pkg::ST_DATA;
                        byteLeft <= 3'd0;
                    end
                end
                flash_multi_io_read_pkg::ST_WRAPCFG:
                begin
                    opShift <= next_op;
                    if (bitCnt == 5'd7)
                    begin
                        wrapCfg.enable <= ~next_op[`WRAP_DISABLE_BIT];
                        if (!next_op[`WRAP_DISABLE_BIT])
                        begin
                            wrapCfg.depth <= next_op[`WRAP_DEPTH_LSB +: 2];
                        end
                        state <= flash_multi_io_read_pkg::ST_IGNORE;
                    end
                end
                default: ;
            endcase
        end
        else if (sclkFall && state == flash_multi_io_read_pkg::ST_DATA)
        begin
            if (quadData)
            begin
                sioOut <= dataSrc[7:4];
                sioOe <= 4'hf;
                dataShift <= {dataSrc[3:0], 4'h0};
                byteLeft <= (byteLeft == 3'd0) ? 3'd4 : byteLeft - 3'd4;
            end
            else
            begin
                sioOut <= {2'b00, dataSrc[7:6]};
                sioOe <= 4'h3;
                dataShift <= {dataSrc[5:0], 2'b00};
                byteLeft <= (byteLeft == 3'd0) ? 3'd6 : byteLeft - 3'd2;
            end
            if (byteLeft == 3'd0)
            begin
                memAddr <= next_memAddr;
            end
        end
    end

    assign statusWord = {21'h000000, state, 2'b00, wrapCfg.depth,
                         1'b0, wrapCfg.enable, enhance, writeInProgress};

    // AXI write: both address and data taken in one cycle
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            ctrl <= `CTRL_RESET;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `AXI_RESP_OKAY;
        end
        else
        begin
            awready <= 1'b0;
            wready <= 1'b0;
            if (bvalid && bready)
            begin
                bvalid <= 1'b0;
            end
            if (!bvalid && !awready && awvalid && wvalid)
            begin
                awready <= 1'b1;
                wready <= 1'b1;
                bvalid <= 1'b1;
                bresp <= `AXI_RESP_SLVERR;
                if (awaddr == `REG_CTRL && wstrb[0])
                begin
                    bresp <= `AXI_RESP_OKAY;
                    ctrl <= wdata[1:0];
                end
                else if (awaddr == `REG_CTRL || awaddr == `REG_STATUS)
                begin
                    bresp <= `AXI_RESP_OKAY;
                end
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `AXI_RESP_OKAY;
        end
        else
        begin
            arready <= 1'b0;
            if (rvalid && rready)
            begin
                rvalid <= 1'b0;
            end
            if (!rvalid && !arready && arvalid)
            begin
                arready <= 1'b1;
                rvalid <= 1'b1;
                rdata <= 32'h00000000;
                rresp <= `AXI_RESP_SLVERR;
                if (araddr == `REG_CTRL)
                begin
                    rdata <= {30'h00000000, ctrl};
                    rresp <= `AXI_RESP_OKAY;
                end
                else if (araddr == `REG_STATUS)
                begin
                    rdata <= statusWord;
                    rresp <= `AXI_RESP_OKAY;
                end
            end
        end
    end

endmodule // flash_multi_io_read
`default_nettype wire

// ### logic/flash_multi_io_read_params.svh
// Constants for the multi-line read front end.
// Assumes inclusion by bare name from the design module.
`ifndef FLASH_MULTI_IO_READ_PARAMS_SVH
`define FLASH_MULTI_IO_READ_PARAMS_SVH

`define OP_DUAL_OUTPUT_READ 8'h3b
`define OP_DUAL_IO_READ 8'hbb
`define OP_QUAD_OUTPUT_READ 8'h6b
`define OP_QUAD_IO_READ 8'heb
`define OP_BURST_WRAP_CFG 8'hc0
`define OP_ENHANCE_EXIT 8'hff

`define DUMMY_SINGLE_ADDR 4'd8
`define DUMMY_DUAL_IO_SHORT 4'd4
`define DUMMY_DUAL_IO_LONG 4'd8
`define DUMMY_QUAD_IO_SHORT 4'd4
`define DUMMY_QUAD_IO_LONG 4'd8
`define INDICATOR_CLOCKS 5'd2

`define ADDR_CLOCKS_X1 5'd24
`define ADDR_CLOCKS_X2 5'd12
`define ADDR_CLOCKS_X4 5'd6

`define WRAP_DISABLE_BIT 4
`define WRAP_DEPTH_LSB 0

`define REG_CTRL 4'h0
`define REG_STATUS 4'h4

`define CTRL_QUAD_ENABLE_BIT 0
`define CTRL_DUMMY_SELECT_BIT 1
`define CTRL_RESET 2'h0

`define STAT_WIP_BIT 0
`define STAT_ENHANCE_BIT 1
`define STAT_WRAP_EN_BIT 2
`define STAT_WRAP_DEPTH_LSB 4
`define STAT_STATE_LSB 8

`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// ### logic/flash_multi_io_read_pkg.sv
// Types shared by the multi-line read front end.
// Assumes nothing beyond the constants header.
package flash_multi_io_read_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OPCODE = 3'b001,
        ST_ADDR = 3'b010,
        ST_MODE = 3'b011,
        ST_DUMMY = 3'b100,
        ST_DATA = 3'b101,
        ST_WRAPCFG = 3'b110,
        ST_IGNORE = 3'b111
    } linkState_e;

    typedef enum logic [1:0] {
        RD_DUAL_OUT = 2'b00,
        RD_DUAL_IO = 2'b01,
        RD_QUAD_OUT = 2'b10,
        RD_QUAD_IO = 2'b11
    } readKind_e;

    typedef struct packed {
        logic sclk;
        logic csN;
        logic [3:0] sio;
    } linkIn_s;

    typedef struct packed {
        logic enable;
        logic [1:0] depth;
    } wrapCfg_s;

endpackage

// ### test/flash_multi_io_read_chk.sv
// Assertions on the ports of the multi-line read front end.
// Assumes it is bound onto flash_multi_io_read and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module flash_multi_io_read_chk #(
    parameter int ARRAY_ADDR_W = 21,
    parameter int AXI_ADDR_W = 4
) (
    input wire logic clock, // System clock
    input wire logic srst, // Reset
    input wire logic sclk, // Serial clock
    input wire logic csN, // Select
    input wire logic [3:0] sioOut, // Line values
    input wire logic [3:0] sioOe, // Line enables
    input wire logic awvalid, // Address valid
    input wire logic wvalid, // Data valid
    input wire logic awready, // Address ready
    input wire logic bvalid, // Response valid
    input wire logic bready, // Response ready
    input wire logic [AXI_ADDR_W-1:0] araddr, // Read address
    input wire logic arvalid, // Read valid
    input wire logic arready, // Read ready
    input wire logic [31:0] rdata, // Read data
    input wire logic [1:0] rresp, // Read response
    input wire logic rvalid, // Data valid
    input wire logic rready // Data ready
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    // Pins pass a synchroniser, so allow a few clocks after select rises
    property p_oe_idle;
        csN [*8] |-> sioOe == 4'h0;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("oe idle");
    property p_oe_on_fall;
        $rose(|sioOe) |-> !sclk && !csN;
    endproperty
    a_oe_on_fall: assert property (p_oe_on_fall) else $error("oe edge");
    property p_out_on_fall;
        $changed(sioOut) |-> !sclk;
    endproperty
    a_out_on_fall: assert property (p_out_on_fall) else $error("out");
    property p_aw_answer;
        awvalid && wvalid && !bvalid && !awready |=> awready && bvalid;
    endproperty
    a_aw_answer: assert property (p_aw_answer) else $error("aw answer");
    property p_b_hold;
        bvalid && !bready |=> bvalid;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("b hold");
    property p_ar_answer;
        arvalid && !rvalid && !arready |=> arready ##1 !arready;
    endproperty
    a_ar_answer: assert property (p_ar_answer) else $error("ar answer");
    property p_r_hold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("r hold");
    property p_rd_unmapped;
        arvalid && !rvalid && !arready && araddr != 4'h0 && araddr != 4'h4
            |=> rvalid && rresp == 2'h2 && rdata == 32'h0;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped");
endmodule // flash_multi_io_read_chk

bind flash_multi_io_read flash_multi_io_read_chk #(
    .ARRAY_ADDR_W(ARRAY_ADDR_W), .AXI_ADDR_W(AXI_ADDR_W)
) i_flash_multi_io_read_chk (.clock, .srst, .sclk, .csN, .sioOut, .sioOe,
    .awvalid, .wvalid, .awready, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);
`default_nettype wire

// ### test/flash_host_model.sv
// Behavioural host controller: select, serial clock and data lines.
// Assumes the bench resolves the shared lines from both enables.
`timescale 1ns/1ns
`default_nettype none
module flash_host_model (
    output logic sclk, // Parked high outside frames
    output logic csN, // Select, active low
    output logic [3:0] hostOut, // Driven line values
    output logic [3:0] hostOe, // High where the host drives
    input wire logic [3:0] sioLine // Resolved lines
);
    logic [7:0] rx [0:7];

    initial
    begin
        sclk = 1'b1;
        csN = 1'b1;
        hostOut = 4'h0;
        hostOe = 4'h0;
    end

    task automatic sel(input logic v);
        #40 csN = v;
        hostOe = 4'h0;
        #200;
    endtask

    // Change after the fall so the rise sees settled lines
    task automatic shift(input logic [31:0] v, input int n, input int w);
        for (int i = n - 1; i >= 0; i--)
        begin
            sclk = 1'b0;
            hostOe = 4'((1 << w) - 1);
            hostOut = 4'((v >> (i * w)) & ((1 << w) - 1));
            #62 sclk = 1'b1;
            #63;
        end
    endtask

    // Released lines read back inverted, never the old data
    task automatic recv(input int nb, input int w);
        hostOe = 4'h0;
        for (int b = 0; b < nb; b++)
            for (int k = 0; k < 8 / w; k++)
            begin
                sclk = 1'b0;
                #62 sclk = 1'b1;
                rx[b] = 8'((rx[b] << w) | (sioLine & 4'((1 << w) - 1)));
                #63;
            end
    endtask
endmodule // flash_host_model
`default_nettype wire

// ### test/test_flash_multi_io_read.sv
// Self-checking bench for the multi-line read front end.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
`define CHECK(a, e) \
    begin \
        checks++; \
        if ((a) !== (e)) \
        begin \
            badCount++; \
            $display("Error at %0t: got %h expected %h", $time, a, e); \
        end \
    end
module test_flash_multi_io_read;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic writeInProgress = 1'b0;
    logic driven = 1'b0;
    logic [7:0] memData = 8'h00;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, sclk, csN;
    logic [1:0] bresp, rresp;
    logic [3:0] sioIn, sioOut, sioOe, hostOut, hostOe;
    logic [20:0] memAddr;
    int badCount = 0, checks = 0;

    always #2 clock = ~clock;
    assign sioIn = (sioOe & sioOut) | (~sioOe & hostOe & hostOut)
        | (~sioOe & ~hostOe & ~hostOut);

    function automatic logic [7:0] memByte(input logic [20:0] a);
        return a[7:0] ^ a[20:13] ^ 8'h3c;
    endfunction

    always @(posedge clock)
    begin
        memData <= memByte(memAddr);
        driven <= driven | (|sioOe);
    end

    flash_multi_io_read i_flash_multi_io_read (.clock, .srst, .sclk, .csN,
        .sioIn, .sioOut, .sioOe, .writeInProgress, .memAddr, .memData,
        .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready);
    flash_host_model i_flash_host_model (.sclk, .csN, .hostOut, .hostOe,
        .sioLine(sioIn));

    task automatic results();
        $display("checks %0d errors %0d", checks, badCount);
        if (badCount == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic waitHigh(input logic rd);
        for (int n = 0; n < 100; n++)
        begin
            @(posedge clock);
            awvalid <= awvalid && awready !== 1'b1;
            wvalid <= wvalid && wready !== 1'b1;
            arvalid <= arvalid && arready !== 1'b1;
            if ((rd ? rvalid : bvalid) === 1'b1)
            begin
                bready <= 1'b0;
                rready <= 1'b0;
                return;
            end
        end
        badCount++;
        results();
    endtask

    task automatic axiWrite(input logic [3:0] a, input logic [31:0] d,
            input logic [1:0] er);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        waitHigh(1'b0);
        `CHECK(bresp, er)
    endtask

    task automatic axiRead(input logic [3:0] a, input logic [1:0] er);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        waitHigh(1'b1);
        rd = rdata;
        `CHECK(rresp, er)
    endtask

    task automatic reset();
        @(posedge clock);
        srst <= 1'b1;
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        repeat (8) @(posedge clock);
    endtask

    // Opcode 00h stands for an enhance frame that skips the opcode
    task automatic rdFrame(input logic [7:0] op, input logic [20:0] a,
            input int aw, input logic [7:0] ind, input int dum,
            input int dw, input int nb);
        i_flash_host_model.sel(1'b0);
        if (op != 8'h00)
            i_flash_host_model.shift(32'(op), 8, 1);
        i_flash_host_model.shift(32'(a), 24 / aw, aw);
        if (aw == 4)
            i_flash_host_model.shift(32'(ind), 2, 4);
        i_flash_host_model.shift(32'h0, dum, aw);
        i_flash_host_model.recv(nb, dw);
        i_flash_host_model.sel(1'b1);
    endtask

    task automatic wrapCfg(input logic [7:0] v);
        i_flash_host_model.sel(1'b0);
        i_flash_host_model.shift({16'h0, 8'hc0, v}, 16, 1);
        i_flash_host_model.sel(1'b1);
    endtask

    task automatic checkRx(input logic [20:0] a, input int n, input int d);
        logic [20:0] e;
        for (int b = 0; b < n; b++)
        begin
            e = a + 21'(b);
            if (d != 0)
                e = (a & ~21'(d - 1)) | (e & 21'(d - 1));
            `CHECK(i_flash_host_model.rx[b], memByte(e))
        end
    endtask

    task automatic tRegs();
        axiRead(4'h4, 2'h0);
        `CHECK(rd, 32'h0)
        axiWrite(4'hc, 32'h3, 2'h2);
        axiRead(4'hc, 2'h2);
        axiWrite(4'h0, 32'hffff_fffe, 2'h0);
        wstrb <= 4'h0;
        axiWrite(4'h0, 32'h1, 2'h0);
        wstrb <= 4'hf;
        axiRead(4'h0, 2'h0);
        `CHECK(rd, 32'h2)
    endtask

    task automatic tDual();
        rdFrame(8'h3b, 21'h1ffffe, 1, 8'h00, 8, 2, 3);
        checkRx(21'h1ffffe, 3, 0);
        for (int ds = 0; ds < 2; ds++)
        begin
            axiWrite(4'h0, 32'(ds * 2), 2'h0);
            rdFrame(8'hbb, 21'h0a5c3, 2, 8'h00, 4 + ds * 4, 2, 2);
            checkRx(21'h0a5c3, 2, 0);
        end
        axiRead(4'h4, 2'h0);
        `CHECK(rd[1], 1'b0)
    endtask

    task automatic tQuad();
        axiWrite(4'h0, 32'h0, 2'h0);
        driven = 1'b0;
        rdFrame(8'h6b, 21'h00ff0, 1, 8'h00, 8, 4, 2);
        `CHECK(driven, 1'b0)
        axiWrite(4'h0, 32'h1, 2'h0);
        rdFrame(8'h6b, 21'h00ff0, 1, 8'h00, 8, 4, 4);
        checkRx(21'h00ff0, 4, 0);
        `CHECK(sioOe, 4'h0)
        @(posedge clock);
        writeInProgress <= 1'b1;
        driven = 1'b0;
        rdFrame(8'heb, 21'h00100, 4, 8'hff, 4, 4, 2);
        `CHECK(driven, 1'b0)
        @(posedge clock);
        writeInProgress <= 1'b0;
        rdFrame(8'h3b, 21'h00100, 1, 8'h00, 8, 2, 1);
        checkRx(21'h00100, 1, 0);
    endtask

    task automatic tEnhance();
        rdFrame(8'heb, 21'h01234, 4, 8'ha5, 4, 4, 2);
        checkRx(21'h01234, 2, 0);
        axiRead(4'h4, 2'h0);
        `CHECK(rd[1], 1'b1)
        rdFrame(8'h00, 21'h05678, 4, 8'h5a, 4, 4, 2);
        checkRx(21'h05678, 2, 0);
        rdFrame(8'h00, 21'h09abc, 4, 8'haa, 4, 4, 2);
        checkRx(21'h09abc, 2, 0);
        rdFrame(8'h6b, 21'h00200, 1, 8'h00, 8, 4, 2);
        checkRx(21'h00200, 2, 0);
        rdFrame(8'heb, 21'h00300, 4, 8'h0f, 4, 4, 1);
        i_flash_host_model.sel(1'b0);
        i_flash_host_model.shift(32'hffff_ffff, 8, 4);
        i_flash_host_model.sel(1'b1);
        axiRead(4'h4, 2'h0);
        `CHECK(rd[1], 1'b0)
        rdFrame(8'h3b, 21'h00400, 1, 8'h00, 8, 2, 1);
        checkRx(21'h00400, 1, 0);
    endtask

    task automatic tWrap();
        logic [20:0] a;
        for (int d = 0; d < 4; d++)
        begin
            a = 21'h01300 + 21'(8 << d) - 21'd3;
            wrapCfg(8'(d));
            axiRead(4'h4, 2'h0);
            `CHECK(rd[5:2], {2'(d), 2'b01})
            rdFrame(8'heb, a, 4, 8'hff, 4, 4, 5);
            checkRx(a, 5, 8 << d);
        end
        wrapCfg(8'h13);
        rdFrame(8'heb, a, 4, 8'hff, 4, 4, 5);
        checkRx(a, 5, 0);
        wrapCfg(8'h01);
        reset();
        axiRead(4'h4, 2'h0);
        `CHECK(rd[2], 1'b0)
    endtask

    initial
    begin
        reset();
        tRegs();
        tDual();
        tQuad();
        tEnhance();
        tWrap();
        results();
    end
endmodule // test_flash_multi_io_read
`default_nettype wire
